// *** rtl/lf_tick_sel.sv ***
// low-frequency tick source: picks one of three tick enables
// assumes tick inputs are one-cycle pulses synchronous to clk_i
`timescale 1ns/10ps
`include "mfi_regs.svh"
module lf_tick_sel
  import mfi_pkg::*;
#(
  parameter int SYS_DIV = `MFI_SYS_DIV
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire lf_sel_type sel_i,
  input wire logic xtal_tick_i,
  input wire logic internal_tick_i,
  output logic tick_o
);
  initial
  begin
    if (SYS_DIV < 2 || SYS_DIV > 256) $error("SYS_DIV out of range");
  end

  logic [7:0] div_r; // system clock prescaler
  logic sys_tick; // one pulse per SYS_DIV clocks

  assign sys_tick = (div_r == 8'(SYS_DIV - 1));

  ////////////////////////////////////////////////////////////////////
  // prescaler for the system-oscillator option
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i) div_r <= 8'h00;
    else if (sys_tick) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end

  // registered selection; reserved code yields no ticks
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i) tick_o <= 1'b0;
    else
    begin
      unique case (sel_i)
        LF_XTAL: tick_o <= xtal_tick_i;
        LF_INTERNAL: tick_o <= internal_tick_i;
        LF_SYSDIV: tick_o <= sys_tick;
        default: tick_o <= 1'b0;
      endcase
    end
  end
endmodule : lf_tick_sel

// *** rtl/mfi_pkg.sv ***
// types shared by the grouped interrupt logic
// assumes the register header sits beside it
package mfi_pkg;
  // source index within the flag and enable fields
  typedef enum logic [2:0] {
    SRC_CONV = 3'b000,
    SRC_RTC = 3'b001,
    SRC_TB = 3'b010,
    SRC_SERIAL = 3'b011,
    SRC_CRF = 3'b100
  } src_type;
  // low-frequency source selection
  typedef enum logic [1:0] {
    LF_XTAL = 2'b00,
    LF_INTERNAL = 2'b01,
    LF_SYSDIV = 2'b10,
    LF_RSVD = 2'b11
  } lf_sel_type;
  // service sequencer
  typedef enum logic [0:0] {
    SV_IDLE = 1'b0,
    SV_REQ = 1'b1
  } sv_state_type;
endpackage : mfi_pkg

// *** rtl/mfi_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes inclusion from the modules and the bench of the grouped interrupt logic
`ifndef MFI_REGS_SVH
`define MFI_REGS_SVH

// byte offsets on the avalon word bus
`define MFI_CTRL_OFS 8'h00
`define MFI_FLAG_OFS 8'h04
`define MFI_RTC_OFS 8'h08
`define MFI_STAT_OFS 8'h0c
`define MFI_EVST_OFS 8'h10
`define MFI_EVMSK_OFS 8'h14

// control word: global and group enables, then source enables
`define MFI_GLOBAL_EN_BIT 0
`define MFI_G0_EN_BIT 1
`define MFI_G1_EN_BIT 2
`define MFI_SRC_EN_LSB 8
// flag word: source flags low, group flags above
`define MFI_SRC_FLAG_LSB 0
`define MFI_G0_FLAG_BIT 8
`define MFI_G1_FLAG_BIT 9

// reset values
`define MFI_CTRL_RST 32'h0000_0000
`define MFI_RTC_RATE_RST 3'h0

// divider exponents
`define MFI_RTC_EXP_BASE 5'h08
`define MFI_TB_EXP_BASE 5'h0c
// system oscillator divided by four for the low-frequency tick
`define MFI_SYS_DIV 4

// vectors
`define MFI_VEC_G0 8'h14
`define MFI_VEC_G1 8'h18

`endif

// *** rtl/multifunction_irq_ctrl.sv ***
// grouped interrupt controller: five sources merged into two vectored groups,
// with the real time clock and time base dividers
// assumes an avalon-mm master on clk_i and a core that pulses ack while req is high
//
// Operation
// - conversion done sets flag, feeds group 1
// - any enabled member event sets its group flag
// - acknowledge branches to 014H or 018H
// - servicing clears group flag and global enable
// - servicing keeps source flags; software clears them
// - serial byte or address match feeds group 0
// - either measurement counter overflow feeds group 0
// - rtc divider overflow sets flag, group 1
// - rtc period 2^8..2^15 by 3-bit rate
// - low-frequency clock from configured source
// - time base overflow sets flag, group 1
// - time base ratio 2^12..2^15 configured
// - no acknowledge while return stack full
// - disabling blocks service, flags stay set
// - any source flag wakes from power-down
// - entry pushes only the program counter
// - group 0 ranks above group 1
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "mfi_regs.svh"
module multifunction_irq_ctrl
  import mfi_pkg::*;
#(
  parameter int NSRC = 5,
  parameter int DIV_WIDTH = 15
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // peripheral events, one-cycle pulses
  input wire logic conv_done_i,
  input wire logic serial_byte_done_i,
  input wire logic serial_addr_match_i,
  input wire logic crf_counter_a_ovf_i,
  input wire logic crf_counter_b_ovf_i,
  // low-frequency tick enables and configuration straps
  input wire logic xtal_32k_tick_i,
  input wire logic internal_low_freq_osc_tick_i,
  input wire logic [1:0] lf_source_cfg_i,
  input wire logic [1:0] timebase_ratio_cfg_i,
  // core sequencer
  input wire logic stack_full_i,
  input wire logic higher_irq_pending_i,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  output logic [7:0] irq_vector_o,
  output logic push_pc_o,
  output logic wake_o,
  // software event interrupt
  output logic irq_o
);
  initial
  begin
    if (NSRC != 5) $error("NSRC must be 5");
    if (DIV_WIDTH < 15) $error("DIV_WIDTH too small for 2^15");
  end

  ////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] ctrl_r; // enables
  logic [NSRC-1:0] src_flag_r; // per-source sticky flags
  logic [NSRC-1:0] src_flag_nxt;
  logic g0_flag_r; // group request flags
  logic g1_flag_r;
  logic [2:0] rtc_rate_r; // rtc_rate_bit2..0
  logic [2:0] evst_r; // sticky events: g0 taken, g1 taken, wake
  logic [2:0] evmsk_r; // event mask
  logic bus_wait_r; // waitrequest register
  logic cfg_done_r; // straps captured
  lf_sel_type lf_sel_r; // captured source selection
  logic [1:0] tb_ratio_r; // captured time base ratio
  sv_state_type sv_state_r; // service sequencer
  logic sv_g0_r; // group being offered is group 0
  logic lf_tick; // selected low-frequency tick
  logic rtc_ovf; // rtc period end
  logic tb_ovf; // time base period end
  logic [4:0] rtc_exp;
  logic [4:0] tb_exp;
  logic [NSRC-1:0] src_set; // hardware set pulses
  logic [NSRC-1:0] src_clr; // software clear strobes
  logic [NSRC-1:0] src_en; // source enables
  logic [NSRC-1:0] src_set_en; // enabled set pulses
  logic g0_set; // group set pulses
  logic g1_set;
  logic global_irq_enable;
  logic group0_irq_enable;
  logic group1_irq_enable;
  logic g0_ok; // group eligible for service
  logic g1_ok;
  logic take; // acknowledge accepted
  logic take_g0;
  logic take_g1;
  logic acc; // bus access completing this edge
  logic wr_ctrl, wr_flag, wr_rtc, wr_msk;
  logic rd_evst;
  logic [31:0] rd_mux; // read data selection
  logic [31:0] wmask; // byte-enable mask
  logic [31:0] flag_word;

  // byte enables expanded to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{be[i]}};
    return m;
  endfunction : be_mask

  // write strobe for one word address
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return (a == ofs);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////
  // configuration straps, caught on the first edge after reset release
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_done_r <= 1'b0;
      lf_sel_r <= LF_XTAL;
      tb_ratio_r <= 2'h0;
    end
    else if (!cfg_done_r)
    begin
      cfg_done_r <= 1'b1;
      lf_sel_r <= lf_sel_type'(lf_source_cfg_i);
      tb_ratio_r <= timebase_ratio_cfg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // low-frequency tick and the two dividers
  lf_tick_sel u_lf (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sel_i(lf_sel_r),
    .xtal_tick_i(xtal_32k_tick_i),
    .internal_tick_i(internal_low_freq_osc_tick_i),
    .tick_o(lf_tick)
  );

  // rtc: 2^(8+rate) ticks per period
  assign rtc_exp = `MFI_RTC_EXP_BASE + {2'b00, rtc_rate_r};
  // time base: 2^(12+ratio), fixed after reset
  assign tb_exp = `MFI_TB_EXP_BASE + {3'b000, tb_ratio_r};

  pow2_divider #(.WIDTH(DIV_WIDTH)) u_rtc_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(lf_tick),
    .exp_i(rtc_exp),
    .ovf_o(rtc_ovf)
  );

  pow2_divider #(.WIDTH(DIV_WIDTH)) u_tb_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(lf_tick),
    .exp_i(tb_exp),
    .ovf_o(tb_ovf)
  );

  ////////////////////////////////////////////////////////////////////
  // bus decode; event status clears on the edge that catches its read data, so no set is lost
  assign acc = (avs_read_i || avs_write_i) && !bus_wait_r;
  assign wmask = be_mask(avs_byteenable_i);
  assign wr_ctrl = acc && avs_write_i && wr_hit(avs_address_i, `MFI_CTRL_OFS);
  assign wr_flag = acc && avs_write_i && wr_hit(avs_address_i, `MFI_FLAG_OFS);
  assign wr_rtc = acc && avs_write_i && wr_hit(avs_address_i, `MFI_RTC_OFS);
  assign wr_msk = acc && avs_write_i && wr_hit(avs_address_i, `MFI_EVMSK_OFS);
  assign rd_evst = avs_read_i && bus_wait_r && wr_hit(avs_address_i, `MFI_EVST_OFS);

  // control fields
  assign global_irq_enable = ctrl_r[`MFI_GLOBAL_EN_BIT];
  assign group0_irq_enable = ctrl_r[`MFI_G0_EN_BIT];
  assign group1_irq_enable = ctrl_r[`MFI_G1_EN_BIT];
  assign src_en = ctrl_r[`MFI_SRC_EN_LSB +: NSRC];

  ////////////////////////////////////////////////////////////////////
  // source events
  assign src_set[SRC_CONV] = conv_done_i;
  assign src_set[SRC_RTC] = rtc_ovf;
  assign src_set[SRC_TB] = tb_ovf;
  assign src_set[SRC_SERIAL] = serial_byte_done_i || serial_addr_match_i;
  assign src_set[SRC_CRF] = crf_counter_a_ovf_i || crf_counter_b_ovf_i;

  // write one to clear a source flag; servicing never touches them
  assign src_clr = wr_flag ? (avs_writedata_i[`MFI_SRC_FLAG_LSB +: NSRC]
                              & wmask[`MFI_SRC_FLAG_LSB +: NSRC]) : '0;

  // per-source flag update, set over clear
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_src
      assign src_flag_nxt[gi] = (src_flag_r[gi] && !src_clr[gi]) || src_set[gi];
      assign src_set_en[gi] = src_set[gi] && src_en[gi];
    end
  endgenerate

  // group membership; an enabled source event raises its group
  assign g0_set = src_set_en[SRC_SERIAL] || src_set_en[SRC_CRF];
  assign g1_set = src_set_en[SRC_CONV] || src_set_en[SRC_RTC]
                  || src_set_en[SRC_TB];

  ////////////////////////////////////////////////////////////////////
  // service eligibility and priority
  assign g0_ok = global_irq_enable && group0_irq_enable && g0_flag_r
                 && !stack_full_i && !higher_irq_pending_i;
  assign g1_ok = global_irq_enable && group1_irq_enable && g1_flag_r
                 && !stack_full_i && !higher_irq_pending_i;
  // ack counts only if the offered group is still eligible
  assign take = (sv_state_r == SV_REQ) && irq_ack_i
                && (sv_g0_r ? g0_ok : g1_ok);
  assign take_g0 = take && sv_g0_r;
  assign take_g1 = take && !sv_g0_r;

  ////////////////////////////////////////////////////////////////////
  // flags: source and group
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      src_flag_r <= '0;
      g0_flag_r <= 1'b0;
      g1_flag_r <= 1'b0;
    end
    else
    begin
      src_flag_r <= src_flag_nxt;
      // set wins over service clear and software clear
      g0_flag_r <= g0_set || (g0_flag_r && !take_g0 && !(wr_flag
                   && avs_writedata_i[`MFI_G0_FLAG_BIT] && wmask[`MFI_G0_FLAG_BIT]));
      g1_flag_r <= g1_set || (g1_flag_r && !take_g1 && !(wr_flag
                   && avs_writedata_i[`MFI_G1_FLAG_BIT] && wmask[`MFI_G1_FLAG_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register; servicing drops the global enable
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i) ctrl_r <= `MFI_CTRL_RST;
    else
    begin
      if (wr_ctrl) ctrl_r <= (ctrl_r & ~wmask) | (avs_writedata_i & wmask);
      // service wins over a same-cycle write of the enable
      if (take) ctrl_r[`MFI_GLOBAL_EN_BIT] <= 1'b0;
    end
  end

  // rtc rate and event mask
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rtc_rate_r <= `MFI_RTC_RATE_RST;
      evmsk_r <= 3'h0;
    end
    else
    begin
      if (wr_rtc && avs_byteenable_i[0]) rtc_rate_r <= avs_writedata_i[2:0];
      if (wr_msk && avs_byteenable_i[0]) evmsk_r <= avs_writedata_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // service sequencer: offer a vector, wait for the core's ack
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sv_state_r <= SV_IDLE;
      sv_g0_r <= 1'b1;
      irq_req_o <= 1'b0;
      irq_vector_o <= `MFI_VEC_G0;
      push_pc_o <= 1'b0;
    end
    else
    begin
      push_pc_o <= take;
      unique case (sv_state_r)
        SV_IDLE:
        begin
          if (g0_ok || g1_ok)
          begin
            sv_state_r <= SV_REQ;
            sv_g0_r <= g0_ok;
            irq_req_o <= 1'b1;
            irq_vector_o <= g0_ok ? `MFI_VEC_G0 : `MFI_VEC_G1;
          end
        end
        SV_REQ:
        begin
          // withdraw once taken or no longer eligible (stack full etc)
          if (take || !(sv_g0_r ? g0_ok : g1_ok))
          begin
            sv_state_r <= SV_IDLE;
            irq_req_o <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wake and software event interrupt
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wake_o <= 1'b0;
      evst_r <= 3'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      // any raised source wakes, enables aside
      wake_o <= |src_flag_nxt;
      // set wins over the clearing read
      evst_r <= (rd_evst ? 3'h0 : evst_r) | {|src_set, take_g1, take_g0};
      irq_o <= |(evst_r & evmsk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data
  assign flag_word = {22'h0, g1_flag_r, g0_flag_r, 3'h0, src_flag_r};
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      `MFI_CTRL_OFS: rd_mux = ctrl_r;
      `MFI_FLAG_OFS: rd_mux = flag_word;
      `MFI_RTC_OFS: rd_mux = {29'h0, rtc_rate_r};
      `MFI_STAT_OFS: rd_mux = {16'h0, irq_vector_o, 2'h0, tb_ratio_r,
                               lf_sel_r, stack_full_i, irq_req_o};
      `MFI_EVST_OFS: rd_mux = {29'h0, evst_r};
      `MFI_EVMSK_OFS: rd_mux = {29'h0, evmsk_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: waitrequest drops for one cycle per access
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      bus_wait_r <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      bus_wait_r <= !((avs_read_i || avs_write_i) && bus_wait_r);
      if (avs_read_i && bus_wait_r) avs_readdata_o <= rd_mux;
    end
  end

  assign avs_waitrequest_o = bus_wait_r;
endmodule : multifunction_irq_ctrl

// *** rtl/pow2_divider.sv ***
// power-of-two period divider counting low-frequency ticks
// assumes tick_i is a one-cycle enable; exponent may change at any time
`timescale 1ns/10ps
module pow2_divider #(
  parameter int WIDTH = 15
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic [4:0] exp_i,
  output logic ovf_o
);
  initial
  begin
    if (WIDTH < 2 || WIDTH > 31) $error("WIDTH out of range");
  end

  logic [WIDTH-1:0] cnt_r; // free-running tick counter
  logic [WIDTH-1:0] mask; // low exp_i bits set
  logic hit; // counter at end of period

  assign mask = WIDTH'((32'h1 << exp_i) - 32'h1);
  assign hit = tick_i && ((cnt_r & mask) == mask);

  ////////////////////////////////////////////////////////////////////
  // counter and overflow pulse; a rate change takes effect mid-period
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_r <= '0;
      ovf_o <= 1'b0;
    end
    else
    begin
      if (tick_i) cnt_r <= cnt_r + WIDTH'(1);
      ovf_o <= hit;
    end
  end
endmodule : pow2_divider

// *** verif/core_seq_model.sv ***
// behavioural core sequencer: acknowledges an offered interrupt
// assumes the request is a registered level on clk_i
`timescale 1ns/10ps
module core_seq_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic irq_req_i,
  input wire logic [1:0] ack_delay_i,
  output logic irq_ack_o
);
  // cycles the request has been offered
  logic [1:0] wait_r;
  // one ack pulse per offer, after a chosen delay (prompt or slow)
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !irq_req_i || irq_ack_o)
    begin
      wait_r <= 2'h0;
      irq_ack_o <= 1'b0;
    end
    else if (wait_r == ack_delay_i)
      irq_ack_o <= 1'b1;
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule : core_seq_model

// *** verif/multifunction_irq_ctrl_sva.sv ***
// concurrent checks on the ports of the grouped interrupt controller
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/10ps
module multifunction_irq_ctrl_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic avs_write_i,
  input wire logic conv_done_i,
  input wire logic serial_byte_done_i,
  input wire logic serial_addr_match_i,
  input wire logic crf_counter_a_ovf_i,
  input wire logic crf_counter_b_ovf_i,
  input wire logic stack_full_i,
  input wire logic higher_irq_pending_i,
  input wire logic irq_ack_i,
  input wire logic irq_req_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic push_pc_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // any peripheral event pulse
  wire logic any_evt;
  assign any_evt = conv_done_i | serial_byte_done_i | serial_addr_match_i
    | crf_counter_a_ovf_i | crf_counter_b_ovf_i;
  ////////////////////////////////////////////////////////////////////////
  // core takes an offered and still eligible group
  sequence s_taken;
    irq_req_o && irq_ack_i && !stack_full_i && !higher_irq_pending_i;
  endsequence
  // entry: one push pulse, request gone, global enable keeps it gone
  sequence s_entry;
    push_pc_o && !irq_req_o ##1 !push_pc_o && !irq_req_o;
  endsequence
  a_vec_legal: assert property (irq_req_o |-> irq_vector_o inside {8'h14, 8'h18})
    else $error("vector outside the two group entries");
  a_vec_hold: assert property (irq_req_o && $past(irq_req_o) |-> $stable(irq_vector_o))
    else $error("vector moved during an offer");
  a_entry_steps: assert property (s_taken |=> s_entry)
    else $error("entry sequence wrong after acknowledge");
  a_push_cause: assert property (push_pc_o |-> $past(irq_req_o && irq_ack_i))
    else $error("push without an acknowledged request");
  a_stack_block: assert property (stack_full_i |=> !irq_req_o)
    else $error("request offered with stack full");
  a_higher_block: assert property (higher_irq_pending_i |=> !irq_req_o)
    else $error("group offered over a higher source");
  a_wake_event: assert property (any_evt |-> ##2 wake_o)
    else $error("event did not wake");
  // only a software write may drop a set flag
  a_flag_kept: assert property (wake_o && !avs_write_i && !$past(avs_write_i) |=> wake_o)
    else $error("source flag lost without a write");
endmodule : multifunction_irq_ctrl_sva

bind multifunction_irq_ctrl multifunction_irq_ctrl_sva i_multifunction_irq_ctrl_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .avs_write_i(avs_write_i), .conv_done_i(conv_done_i),
  .serial_byte_done_i(serial_byte_done_i), .serial_addr_match_i(serial_addr_match_i),
  .crf_counter_a_ovf_i(crf_counter_a_ovf_i), .crf_counter_b_ovf_i(crf_counter_b_ovf_i),
  .stack_full_i(stack_full_i), .higher_irq_pending_i(higher_irq_pending_i),
  .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
  .push_pc_o(push_pc_o), .wake_o(wake_o));

// *** verif/multifunction_irq_ctrl_test.sv ***
// self-checking bench of the grouped interrupt controller
// assumes the register map of the header and a core model that acks
`timescale 1ns/10ps
`include "mfi_regs.svh"
module multifunction_irq_ctrl_test;
  import mfi_pkg::*;
  localparam logic [7:0] CT = `MFI_CTRL_OFS;
  localparam logic [7:0] FL = `MFI_FLAG_OFS;
  localparam logic [7:0] EVS = `MFI_EVST_OFS;
  localparam logic [7:0] EVM = `MFI_EVMSK_OFS;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [4:0] evt = 5'h00; // conv, serial byte, serial match, crf a, crf b
  logic xt_tick = 1'b0;
  logic in_tick = 1'b0;
  logic [1:0] lf_cfg = 2'h0;
  logic [1:0] tb_cfg = 2'h1; // time base exponent 13
  logic stack_full = 1'b0;
  logic higher = 1'b0;
  logic [1:0] ack_delay = 2'h0;
  logic [31:0] rdata, q;
  logic [31:0] rng = 32'h0000_078f;
  logic wreq, ack, req, push, wake, irq;
  logic [7:0] vec;
  int cyc = 0;
  int n_errors = 0;
  int compares = 0;
  int t, s;
  always #4 clk_i = ~clk_i;
  multifunction_irq_ctrl i_multifunction_irq_ctrl (.clk_i(clk_i), .rstn_i(rstn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .conv_done_i(evt[0]), .serial_byte_done_i(evt[1]), .serial_addr_match_i(evt[2]),
    .crf_counter_a_ovf_i(evt[3]), .crf_counter_b_ovf_i(evt[4]), .xtal_32k_tick_i(xt_tick),
    .internal_low_freq_osc_tick_i(in_tick), .lf_source_cfg_i(lf_cfg),
    .timebase_ratio_cfg_i(tb_cfg), .stack_full_i(stack_full), .higher_irq_pending_i(higher),
    .irq_ack_i(ack), .irq_req_o(req), .irq_vector_o(vec), .push_pc_o(push), .wake_o(wake),
    .irq_o(irq));
  core_seq_model i_core_seq_model (.clk_i(clk_i), .rstn_i(rstn_i), .irq_req_i(req),
    .ack_delay_i(ack_delay), .irq_ack_o(ack));
  ////////////////////////////////////////////////////////////////////////
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // source bit of an event line
  function automatic int src_of(input int e);
    return (e == 0) ? 0 : (e < 3) ? 3 : 4;
  endfunction : src_of
  // conv, rtc and time base sit in group 1
  function automatic logic [7:0] vec_of(input int sr);
    return (sr < 3) ? `MFI_VEC_G1 : `MFI_VEC_G0;
  endfunction : vec_of
  function automatic logic [31:0] ctrl_of(input int sr);
    return 32'h1 | ((sr < 3) ? 32'h4 : 32'h2) | (32'h100 << sr);
  endfunction : ctrl_of
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // one avalon access; ev pulses a conversion at the landing edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic ev);
    int k;
    k = 0;
    @(posedge clk_i);
    addr <= a;
    wr <= we;
    rd <= !we;
    wdata <= d;
    do
    begin
      @(posedge clk_i);
      k++;
      evt[0] <= ev & wreq;
    end
    while (wreq !== 1'b0 && k < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 20)
      n_errors++;
  endtask : bus
  task automatic pulse(input int e);
    @(posedge clk_i);
    evt[e] <= 1'b1;
    @(posedge clk_i);
    evt[e] <= 1'b0;
  endtask : pulse
  // bounded wait on request (0) or push (1)
  task automatic wait_for(input logic sel, input int lim);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while ((sel ? push : req) !== 1'b1 && k < lim);
    t = cyc;
    check("handshake in time", k < lim, 32'h1);
  endtask : wait_for
  task automatic arm(input int sr);
    bus(1'b1, FL, 32'h0000_031f, 1'b0);
    bus(1'b1, CT, ctrl_of(sr), 1'b0);
  endtask : arm
  // one overflow-aligned period of a divider source, in cycles
  task automatic measure(input int sr, input int exp);
    int t1;
    xt_tick <= (lf_cfg == 2'h0);
    in_tick <= (lf_cfg == 2'h1);
    for (int n = 0; n < 3; n++)
    begin
      arm(sr);
      t1 = t;
      wait_for(1'b0, 40000);
      wait_for(1'b1, 20);
    end
    check("period", t - t1, exp);
    $display("period test done");
  endtask : measure
  task automatic do_reset(input logic [1:0] lf);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    lf_cfg <= lf;
    xt_tick <= 1'b0;
    in_tick <= 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset(2'h0);
    check("reset vector", vec, `MFI_VEC_G0);
    bus(1'b0, CT, 32'h0, 1'b0);
    check("ctrl reset", q, `MFI_CTRL_RST);
    bus(1'b0, 8'h1c, 32'h0, 1'b0);
    check("unmapped", q, 32'h0);
    // every event line through its group, served by the core model
    for (int e = 0; e < 5; e++)
    begin
      s = src_of(e);
      ack_delay <= rng[1:0];
      rng = xs(rng);
      arm(s);
      pulse(e);
      wait_for(1'b0, 20);
      check("vector", vec, vec_of(s));
      wait_for(1'b1, 20);
      bus(1'b0, FL, 32'h0, 1'b0);
      check("flags after entry", q, 32'h1 << s);
      bus(1'b0, CT, 32'h0, 1'b0);
      check("ctrl after entry", q, ctrl_of(s) & 32'hffff_fffe);
    end
    $display("event test done");
    // random events with every source disabled
    arm(0);
    bus(1'b1, CT, 32'h0, 1'b0);
    q = 32'h0;
    repeat (200)
    begin
      rng = xs(rng);
      @(posedge clk_i);
      evt <= rng[4:0] & rng[9:5] & rng[14:10];
      q = q | {27'h0, |(rng[4:3] & rng[9:8] & rng[14:13]),
        |(rng[2:1] & rng[7:6] & rng[12:11]), 2'h0, rng[0] & rng[5] & rng[10]};
    end
    @(posedge clk_i);
    evt <= 5'h00;
    repeat (3) @(posedge clk_i);
    check("wake", wake, q != 32'h0);
    t = q;
    bus(1'b0, FL, 32'h0, 1'b0);
    check("random flags", q, t);
    $display("random test done");
    // stack full, higher source, then priority between groups
    stack_full <= 1'b1;
    arm(0);
    pulse(0);
    repeat (20) @(posedge clk_i);
    check("held by stack", req, 1'b0);
    stack_full <= 1'b0;
    higher <= 1'b1;
    repeat (20) @(posedge clk_i);
    check("held by higher", req, 1'b0);
    higher <= 1'b0;
    wait_for(1'b0, 20);
    wait_for(1'b1, 20);
    bus(1'b1, FL, 32'h0000_031f, 1'b0);
    bus(1'b1, CT, 32'h0000_0906, 1'b0);
    pulse(0);
    pulse(1);
    repeat (5) @(posedge clk_i);
    check("disabled idle", req, 1'b0);
    bus(1'b0, FL, 32'h0, 1'b0);
    check("flags kept", q, 32'h0000_0309);
    for (int g = 0; g < 2; g++)
    begin
      bus(1'b1, CT, 32'h0000_0907, 1'b0);
      wait_for(1'b0, 20);
      check("rank", vec, g ? `MFI_VEC_G1 : `MFI_VEC_G0);
      wait_for(1'b1, 20);
    end
    bus(1'b1, FL, 32'h1, 1'b1);
    bus(1'b0, FL, 32'h0, 1'b0);
    check("set beats clear", q, 32'h0000_0209);
    $display("priority test done");
    // event interrupt raised, cleared by read, then masked
    bus(1'b0, EVS, 32'h0, 1'b0);
    for (int m = 1; m >= 0; m--)
    begin
      bus(1'b1, EVM, m, 1'b0);
      arm(3);
      pulse(1);
      wait_for(1'b1, 20);
      repeat (3) @(posedge clk_i);
      check("irq level", irq, m);
      bus(1'b0, EVS, 32'h0, 1'b0);
      check("event status", q, 32'h5);
      repeat (3) @(posedge clk_i);
      check("irq cleared", irq, 1'b0);
    end
    $display("interrupt test done");
    // divider periods for each low-frequency source
    measure(1, 256);
    bus(1'b1, 8'h08, 32'h2, 1'b0);
    measure(1, 1024);
    measure(2, 8192);
    do_reset(2'h1);
    measure(1, 256);
    do_reset(2'h2);
    measure(1, 256 * `MFI_SYS_DIV);
    give_verdict();
  end
endmodule : multifunction_irq_ctrl_test
